// File: logic/dual_uart_pkg.sv
// constants shared by the dual serial controller host port and its transmit fifo
package dual_uart_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int BAUD_RATE = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
   localparam int CNT_W = 16;
   localparam int NCH = 2;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int FIFO_DEPTH = 32;

   // register offsets on the address inputs; channel registers repeat at CH_SEL_BIT
   localparam logic [ADDR_W-1:0] REG_MODE = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'h1;
   localparam logic [ADDR_W-1:0] REG_CMD = 4'h2;
   localparam logic [ADDR_W-1:0] REG_DATA = 4'h3;
   localparam logic [ADDR_W-1:0] REG_INT = 4'h4;
   localparam logic [ADDR_W-1:0] REG_VEC = 4'h5;
   localparam logic [ADDR_W-1:0] REG_OPCR = 4'h6;
   localparam logic [ADDR_W-1:0] REG_OPSET = 4'h7;
   localparam logic [ADDR_W-1:0] REG_OPCLR = 4'hE;
   localparam logic [ADDR_W-1:0] REG_TEST = 4'hF;
   localparam logic [ADDR_W-1:0] CH_OFF_MASK = 4'h7;
   localparam logic [ADDR_W-1:0] CH_REG_SPAN = 4'h4;
   localparam int CH_SEL_BIT = 3;

   localparam logic [DATA_W-1:0] VEC_RESET = 8'h0F;

   // command register fields
   localparam int CMD_RX_EN = 0;
   localparam int CMD_RX_DIS = 1;
   localparam int CMD_TX_EN = 2;
   localparam int CMD_TX_DIS = 3;
   localparam int CMD_CODE_LSB = 4;
   localparam logic [2:0] CMD_RST_PTR = 3'h1;
   localparam logic [2:0] CMD_RST_ERR = 3'h4;

   // second mode register channel mode field
   localparam int CHM_LSB = 6;
   localparam logic [1:0] CHM_LOCAL = 2'h2;

   // status and interrupt bit positions
   localparam int ST_RXRDY = 0;
   localparam int ST_TXRDY = 2;
   localparam int ST_TXEMT = 3;
   localparam int ST_OVR = 4;
   localparam int INT_TXRDY = 0;
   localparam int INT_RXRDY = 1;
   localparam int INT_STRIDE = 4;
   localparam int OPCR_RXRDY_A = 0;

   // frame: start at 0, data 1..8, stop at 9
   localparam logic [3:0] BIT_DATA_LAST = 4'h8;
   localparam logic [3:0] BIT_STOP = 4'h9;
   localparam logic LINE_MARK = 1'b1;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACCESS = 3'b010,
      BUS_ACK = 3'b100
   } bus_state_t;
endpackage

// File: logic/dual_uart_fifo.sv
// synchronous fifo with valid/ready on both sides, used as a transmit queue
`timescale 1ns/1ps
module dual_uart_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // fill side
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [W-1:0] i_wr_data,
   // drain side
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [W-1:0] o_rd_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW:0] wp;
      logic [PW:0] rp;
   } fifo_state_t;

   fifo_state_t q;
   fifo_state_t n;
   logic full;
   logic empty;

   // extra pointer bit tells full from empty without a counter
   assign empty = (q.wp == q.rp);
   assign full = (q.wp[PW] != q.rp[PW]) && (q.wp[PW-1:0] == q.rp[PW-1:0]);
   assign o_wr_ready = !full;
   assign o_rd_valid = !empty;
   assign o_rd_data = q.mem[q.rp[PW-1:0]];

   always_comb begin
      n = q;
      if (i_wr_valid && !full) begin
         n.mem[q.wp[PW-1:0]] = i_wr_data;
         n.wp = q.wp + 1'b1;
      end
      if (i_rd_ready && !empty) begin
         n.rp = q.rp + 1'b1;
      end
      if (i_rst) begin
         n.wp = '0;
         n.rp = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst || i_clk_en) begin
         q <= n;
      end
   end
endmodule

// File: logic/dual_uart_host_bus_pins.sv
// host bus pins, register file and serial lines of a dual asynchronous serial controller
// What this block does
// - chip select low enables transfers on data bus, steered by strobe and address.
// - every data bus line is released a few clock edges after chip select rises, except during an interrupt acknowledge vector cycle.
// - strobe high at cycle start means read, low means write; device obeys.
// - four address inputs choose which register or port is accessed.
// - reset drives output port pins high, idles channels, transmit lines at mark.
// - reset clears status, interrupt, output port registers, test modes, mode pointer.
// - transfer acknowledge is driven low when read, write or vector cycle completes.
// - open-drain interrupt request pulled low while any unmasked condition is true.
// - interrupt acknowledge puts vector on bus; acknowledge only with interrupt pending.
// - receivers take least significant bit first; high is mark, low is space.
// - transmitters send least significant bit first; high is mark, low is space.
// - transmit line held at mark when disabled, idle or in local loopback.
`timescale 1ns/1ps
module dual_uart_host_bus_pins
   import dual_uart_pkg::*;
#(
   parameter logic [dual_uart_pkg::CNT_W-1:0] BIT_CYCLES = dual_uart_pkg::CNT_W'(dual_uart_pkg::BIT_CYCLES),
   parameter int FIFO_DEPTH = dual_uart_pkg::FIFO_DEPTH
) (
   // clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // host bus
   input wire logic i_chip_select_n,
   input wire logic i_read_not_write,
   input wire logic [dual_uart_pkg::ADDR_W-1:0] i_register_address,
   input wire logic [dual_uart_pkg::DATA_W-1:0] i_host_data_bus,
   output logic [dual_uart_pkg::DATA_W-1:0] o_host_data_bus,
   output logic o_host_data_bus_oe_n,
   output logic o_transfer_ack_n,
   output logic o_transfer_ack_oe_n,
   output logic o_interrupt_request_n,
   output logic o_interrupt_request_oe_n,
   input wire logic i_interrupt_ack_n,
   // serial lines
   input wire logic i_serial_in_first_channel,
   input wire logic i_serial_in_second_channel,
   output logic o_serial_out_first_channel,
   output logic o_serial_out_second_channel,
   // output port
   output logic [dual_uart_pkg::DATA_W-1:0] o_output_port_pins
);
   import dual_uart_pkg::*;
   localparam logic [CNT_W-1:0] HALF_BIT = BIT_CYCLES >> 1;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic rw_s1;
      logic rw_s2;
      logic iack_s1;
      logic iack_s2;
      logic [ADDR_W-1:0] addr_s1;
      logic [ADDR_W-1:0] addr_s2;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
      logic [NCH-1:0] rx_s1;
      logic [NCH-1:0] rx_s2;
      bus_state_t state;
      logic [DATA_W-1:0] dout;
      logic dout_oe_n;
      logic ack_oe_n;
      logic irq_oe_n;
      logic [NCH-1:0][DATA_W-1:0] mode1;
      logic [NCH-1:0][DATA_W-1:0] mode2;
      logic [NCH-1:0] mode_ptr;
      logic [NCH-1:0] rx_en;
      logic [NCH-1:0] tx_en;
      logic [DATA_W-1:0] imr;
      logic [DATA_W-1:0] vec;
      logic [DATA_W-1:0] opcr;
      logic [DATA_W-1:0] opr;
      logic test;
      logic [NCH-1:0] rx_busy;
      logic [NCH-1:0] rx_rdy;
      logic [NCH-1:0] rx_ovr;
      logic [NCH-1:0][CNT_W-1:0] rx_cnt;
      logic [NCH-1:0][3:0] rx_bit;
      logic [NCH-1:0][DATA_W-1:0] rx_shift;
      logic [NCH-1:0][DATA_W-1:0] rx_hold;
      logic [NCH-1:0] tx_busy;
      logic [NCH-1:0][CNT_W-1:0] tx_cnt;
      logic [NCH-1:0][3:0] tx_bit;
      logic [NCH-1:0][DATA_W+1:0] tx_shift;
      logic [NCH-1:0] tx_pin;
      logic [DATA_W-1:0] op_pins;
   } port_state_t;
   port_state_t q;
   port_state_t n;
   logic ch_sel;
   logic [ADDR_W-1:0] ch_off;
   logic is_ch;
   logic [DATA_W-1:0] isr;
   logic [NCH-1:0][DATA_W-1:0] status;
   logic [NCH-1:0] loop;
   logic [NCH-1:0] tx_line;
   logic [NCH-1:0] fifo_wr_valid;
   logic [NCH-1:0] fifo_wr_ready;
   logic [NCH-1:0] fifo_rd_valid;
   logic [NCH-1:0] fifo_rd_ready;
   logic [NCH-1:0][DATA_W-1:0] fifo_rd_data;
   logic [DATA_W-1:0] rd_val;
   logic irq_pending;
   assign ch_sel = q.addr_s2[CH_SEL_BIT];
   assign ch_off = q.addr_s2 & CH_OFF_MASK;
   assign is_ch = (ch_off < CH_REG_SPAN);
   assign irq_pending = |(isr & q.imr);
   // live status and interrupt sources, one set per channel
   always_comb begin
      isr = '0;
      for (int c = 0; c < NCH; c++) begin
         status[c] = '0;
         status[c][ST_RXRDY] = q.rx_rdy[c];
         status[c][ST_TXRDY] = fifo_wr_ready[c] && q.tx_en[c];
         // empty only counts once enabled, so status reads clear after reset
         status[c][ST_TXEMT] = q.tx_en[c] && !fifo_rd_valid[c] && !q.tx_busy[c];
         status[c][ST_OVR] = q.rx_ovr[c];
         isr[c*INT_STRIDE+INT_TXRDY] = status[c][ST_TXRDY];
         isr[c*INT_STRIDE+INT_RXRDY] = q.rx_rdy[c];
         loop[c] = (q.mode2[c][CHM_LSB+:2] == CHM_LOCAL) || q.test;
         tx_line[c] = q.tx_busy[c] ? q.tx_shift[c][0] : LINE_MARK;
         fifo_rd_ready[c] = !q.tx_busy[c] && q.tx_en[c];
         fifo_wr_valid[c] = i_clk_en && (q.state == BUS_ACCESS) && !q.rw_s2 && is_ch
            && (ch_off == REG_DATA) && (ch_sel == c[0]);
      end
   end
   // read multiplexer
   always_comb begin
      rd_val = '0;
      if (is_ch) begin
         case (ch_off)
            REG_MODE: rd_val = q.mode_ptr[ch_sel] ? q.mode2[ch_sel] : q.mode1[ch_sel];
            REG_STAT: rd_val = status[ch_sel];
            REG_DATA: rd_val = q.rx_hold[ch_sel];
            default: rd_val = '0;
         endcase
      end else begin
         case (q.addr_s2)
            REG_INT: rd_val = isr;
            REG_VEC: rd_val = q.vec;
            REG_OPCR: rd_val = q.opcr;
            REG_OPSET: rd_val = q.opr;
            REG_TEST: rd_val = {7'h00, q.test};
            default: rd_val = '0;
         endcase
      end
   end
   always_comb begin
      n = q;
      // pin inputs pass two flip-flops before any logic reads them
      n.cs_s1 = i_chip_select_n;
      n.cs_s2 = q.cs_s1;
      n.rw_s1 = i_read_not_write;
      n.rw_s2 = q.rw_s1;
      n.iack_s1 = i_interrupt_ack_n;
      n.iack_s2 = q.iack_s1;
      n.addr_s1 = i_register_address;
      n.addr_s2 = q.addr_s1;
      n.din_s1 = i_host_data_bus;
      n.din_s2 = q.din_s1;
      n.rx_s1 = {i_serial_in_second_channel, i_serial_in_first_channel};
      n.rx_s2 = q.rx_s1;
      unique case (q.state)
         BUS_IDLE: begin
            if (!q.cs_s2) begin
               n.state = BUS_ACCESS;
            end else if (!q.iack_s2 && irq_pending) begin
               n.dout = q.vec;
               n.dout_oe_n = 1'b0;
               n.ack_oe_n = 1'b0;
               n.state = BUS_ACK;
            end
         end
         BUS_ACCESS: begin
            if (q.rw_s2) begin
               n.dout = rd_val;
               n.dout_oe_n = 1'b0;
               n.ack_oe_n = 1'b0;
               n.state = BUS_ACK;
               if (is_ch && ch_off == REG_DATA) begin
                  n.rx_rdy[ch_sel] = 1'b0;
               end
            end else if (is_ch && ch_off == REG_DATA && !fifo_wr_ready[ch_sel]) begin
               // full queue: hold the acknowledge back until a slot frees
               n.state = BUS_ACCESS;
            end else begin
               n.ack_oe_n = 1'b0;
               n.state = BUS_ACK;
               if (is_ch) begin
                  case (ch_off)
                     REG_MODE: begin
                        if (q.mode_ptr[ch_sel]) begin
                           n.mode2[ch_sel] = q.din_s2;
                        end else begin
                           n.mode1[ch_sel] = q.din_s2;
                           n.mode_ptr[ch_sel] = 1'b1;
                        end
                     end
                     REG_CMD: begin
                        if (q.din_s2[CMD_RX_EN]) n.rx_en[ch_sel] = 1'b1;
                        if (q.din_s2[CMD_RX_DIS]) n.rx_en[ch_sel] = 1'b0;
                        if (q.din_s2[CMD_TX_EN]) n.tx_en[ch_sel] = 1'b1;
                        if (q.din_s2[CMD_TX_DIS]) n.tx_en[ch_sel] = 1'b0;
                        if (q.din_s2[CMD_CODE_LSB+:3] == CMD_RST_PTR) n.mode_ptr[ch_sel] = 1'b0;
                        if (q.din_s2[CMD_CODE_LSB+:3] == CMD_RST_ERR) n.rx_ovr[ch_sel] = 1'b0;
                     end
                     default: ;
                  endcase
               end else begin
                  case (q.addr_s2)
                     REG_INT: n.imr = q.din_s2;
                     REG_VEC: n.vec = q.din_s2;
                     REG_OPCR: n.opcr = q.din_s2;
                     REG_OPSET: n.opr = q.opr | q.din_s2;
                     REG_OPCLR: n.opr = q.opr & ~q.din_s2;
                     REG_TEST: n.test = q.din_s2[0];
                     default: ;
                  endcase
               end
            end
         end
         BUS_ACK: begin
            // released only once both select and acknowledge are seen high
            if (q.cs_s2 && q.iack_s2) begin
               n.dout_oe_n = 1'b1;
               n.ack_oe_n = 1'b1;
               n.state = BUS_IDLE;
            end
         end
         default: begin
            n.dout_oe_n = 1'b1;
            n.ack_oe_n = 1'b1;
            n.state = BUS_IDLE;
         end
      endcase
      for (int c = 0; c < NCH; c++) begin
         // receiver: sampled mid-bit, shifted in from the top so bit 0 lands first
         if (!q.rx_busy[c]) begin
            if (q.rx_en[c] && !(loop[c] ? tx_line[c] : q.rx_s2[c])) begin
               n.rx_busy[c] = 1'b1;
               n.rx_cnt[c] = HALF_BIT;
               n.rx_bit[c] = '0;
            end
         end else if (q.rx_cnt[c] != '0) begin
            n.rx_cnt[c] = q.rx_cnt[c] - CNT_ONE;
         end else begin
            n.rx_cnt[c] = BIT_CYCLES - CNT_ONE;
            n.rx_bit[c] = q.rx_bit[c] + 4'h1;
            if (q.rx_bit[c] == '0) begin
               // a start bit gone high at mid-bit was a glitch
               if (loop[c] ? tx_line[c] : q.rx_s2[c]) n.rx_busy[c] = 1'b0;
            end else if (q.rx_bit[c] <= BIT_DATA_LAST) begin
               n.rx_shift[c] = {(loop[c] ? tx_line[c] : q.rx_s2[c]), q.rx_shift[c][DATA_W-1:1]};
            end else begin
               n.rx_busy[c] = 1'b0;
               if (loop[c] ? tx_line[c] : q.rx_s2[c]) begin
                  // set wins over a read that clears in the same cycle
                  if (q.rx_rdy[c]) n.rx_ovr[c] = 1'b1;
                  else n.rx_hold[c] = q.rx_shift[c];
                  n.rx_rdy[c] = 1'b1;
               end
            end
         end
         // transmitter: frame is stop, data, start so shifting right sends bit 0 first
         if (!q.tx_en[c]) begin
            n.tx_busy[c] = 1'b0;
         end else if (!q.tx_busy[c]) begin
            if (fifo_rd_valid[c]) begin
               n.tx_shift[c] = {LINE_MARK, fifo_rd_data[c], 1'b0};
               n.tx_busy[c] = 1'b1;
               n.tx_bit[c] = '0;
               n.tx_cnt[c] = BIT_CYCLES - CNT_ONE;
            end
         end else if (q.tx_cnt[c] != '0) begin
            n.tx_cnt[c] = q.tx_cnt[c] - CNT_ONE;
         end else if (q.tx_bit[c] == BIT_STOP) begin
            n.tx_busy[c] = 1'b0;
         end else begin
            n.tx_shift[c] = {LINE_MARK, q.tx_shift[c][DATA_W+1:1]};
            n.tx_bit[c] = q.tx_bit[c] + 4'h1;
            n.tx_cnt[c] = BIT_CYCLES - CNT_ONE;
         end
         n.tx_pin[c] = (q.tx_busy[c] && q.tx_en[c] && !loop[c]) ? q.tx_shift[c][0] : LINE_MARK;
      end
      n.irq_oe_n = !irq_pending;
      n.op_pins = ~q.opr;
      if (q.opcr[OPCR_RXRDY_A]) n.op_pins[0] = !q.rx_rdy[0];
      if (i_rst) begin
         n = '0;
         n.cs_s1 = 1'b1;
         n.cs_s2 = 1'b1;
         n.iack_s1 = 1'b1;
         n.iack_s2 = 1'b1;
         n.rx_s1 = '1;
         n.rx_s2 = '1;
         n.state = BUS_IDLE;
         n.dout_oe_n = 1'b1;
         n.ack_oe_n = 1'b1;
         n.irq_oe_n = 1'b1;
         n.vec = VEC_RESET;
         n.tx_pin = '1;
         n.op_pins = '1;
      end
   end
   // reset acts even while the clock enable is low
   always_ff @(posedge i_core_clk) begin
      if (i_rst || i_clk_en) begin
         q <= n;
      end
   end
   generate
      for (genvar g = 0; g < NCH; g++) begin : g_txq
         dual_uart_fifo #(
            .W(DATA_W),
            .DEPTH(FIFO_DEPTH)
         ) u_txq (
            .i_core_clk(i_core_clk),
            .i_rst(i_rst),
            .i_clk_en(i_clk_en),
            .i_wr_valid(fifo_wr_valid[g]),
            .o_wr_ready(fifo_wr_ready[g]),
            .i_wr_data(q.din_s2),
            .o_rd_valid(fifo_rd_valid[g]),
            .i_rd_ready(fifo_rd_ready[g]),
            .o_rd_data(fifo_rd_data[g])
         );
      end
   endgenerate
   assign o_host_data_bus = q.dout;
   assign o_host_data_bus_oe_n = q.dout_oe_n;
   assign o_transfer_ack_n = q.ack_oe_n;
   assign o_transfer_ack_oe_n = q.ack_oe_n;
   assign o_interrupt_request_n = q.irq_oe_n;
   assign o_interrupt_request_oe_n = q.irq_oe_n;
   assign o_serial_out_first_channel = q.tx_pin[0];
   assign o_serial_out_second_channel = q.tx_pin[1];
   assign o_output_port_pins = q.op_pins;
endmodule

// File: test/dual_uart_host_bus_pins_monitor.sv
// concurrent checks on the host port pins and serial lines
`timescale 1ns/1ps
module dual_uart_host_bus_pins_monitor
   import dual_uart_pkg::*;
#(
   parameter logic [dual_uart_pkg::CNT_W-1:0] BIT_CYCLES = dual_uart_pkg::CNT_W'(dual_uart_pkg::BIT_CYCLES)
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // host bus
   input wire logic i_chip_select_n,
   input wire logic i_read_not_write,
   input wire logic i_interrupt_ack_n,
   input wire logic o_host_data_bus_oe_n,
   input wire logic o_transfer_ack_n,
   input wire logic o_transfer_ack_oe_n,
   input wire logic o_interrupt_request_n,
   input wire logic o_interrupt_request_oe_n,
   // lines and port
   input wire logic o_serial_out_first_channel,
   input wire logic o_serial_out_second_channel,
   input wire logic [dual_uart_pkg::DATA_W-1:0] o_output_port_pins
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // length of the current low run on the first transmit line
   logic [CNT_W-1:0] low_q;
   always_ff @(posedge i_core_clk) begin
      if (i_rst || o_serial_out_first_channel) begin
         low_q <= '0;
      end else begin
         low_q <= low_q + 16'h0001;
      end
   end
   a_reset_idle_pins: assert property (disable iff (1'b0)
      i_rst |=> o_serial_out_first_channel && o_serial_out_second_channel && o_output_port_pins == 8'hFF
      && o_host_data_bus_oe_n && o_transfer_ack_oe_n && o_interrupt_request_oe_n)
      else $error("outputs not idle after reset");
   // pins are synchronised, so release lags the select rise by a few edges
   a_bus_released: assert property ((i_chip_select_n && i_interrupt_ack_n)[*6] |->
      o_host_data_bus_oe_n && o_transfer_ack_oe_n) else $error("bus still driven while deselected");
   a_ack_has_cause: assert property ($fell(o_transfer_ack_oe_n) |->
      !i_chip_select_n || !i_interrupt_ack_n) else $error("ack without a cycle");
   a_data_with_ack: assert property (!o_host_data_bus_oe_n |->
      !o_transfer_ack_oe_n && !o_transfer_ack_n) else $error("data driven without ack low");
   a_write_no_drive: assert property ($fell(o_transfer_ack_oe_n) && !i_chip_select_n && !i_read_not_write
      |-> o_host_data_bus_oe_n) else $error("data bus driven in write");
   a_read_drives: assert property ($fell(o_transfer_ack_oe_n) && !i_chip_select_n && i_read_not_write
      |-> !o_host_data_bus_oe_n) else $error("read acked without data");
   a_iack_vector: assert property ($fell(o_transfer_ack_oe_n) && i_chip_select_n |->
      !o_host_data_bus_oe_n && $past(!o_interrupt_request_oe_n, 2)) else $error("bad vector cycle");
   a_irq_open_drain: assert property (!o_interrupt_request_oe_n |-> !o_interrupt_request_n)
      else $error("request driven high");
   a_tx_bit_span: assert property ($rose(o_serial_out_first_channel) |->
      (low_q % BIT_CYCLES) == 16'h0000) else $error("low run not whole bits");
endmodule
bind dual_uart_host_bus_pins dual_uart_host_bus_pins_monitor #(.BIT_CYCLES(BIT_CYCLES)) mon_u (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_chip_select_n(i_chip_select_n),
   .i_read_not_write(i_read_not_write), .i_interrupt_ack_n(i_interrupt_ack_n),
   .o_host_data_bus_oe_n(o_host_data_bus_oe_n), .o_transfer_ack_n(o_transfer_ack_n),
   .o_transfer_ack_oe_n(o_transfer_ack_oe_n), .o_interrupt_request_n(o_interrupt_request_n),
   .o_interrupt_request_oe_n(o_interrupt_request_oe_n), .o_serial_out_first_channel(o_serial_out_first_channel),
   .o_serial_out_second_channel(o_serial_out_second_channel), .o_output_port_pins(o_output_port_pins));

// File: test/dual_uart_host_model.sv
// host processor model driving the asynchronous parallel bus
`timescale 1ns/1ps
module dual_uart_host_model
   import dual_uart_pkg::*;
(
   // clock
   input wire logic i_core_clk,
   // device side
   input wire logic [dual_uart_pkg::DATA_W-1:0] i_dev_data,
   input wire logic i_dev_data_oe_n,
   input wire logic i_ack_oe_n,
   input wire logic i_ack_n,
   // host side
   output logic o_chip_select_n,
   output logic o_read_not_write,
   output logic [dual_uart_pkg::ADDR_W-1:0] o_register_address,
   output logic o_interrupt_ack_n,
   output logic [dual_uart_pkg::DATA_W-1:0] o_bus_line
);
   logic host_oe = 1'b0;
   logic [DATA_W-1:0] host_d = 8'h00;
   logic [DATA_W-1:0] float_q = 8'h5A;
   initial begin
      o_chip_select_n = 1'b1;
      o_read_not_write = 1'b1;
      o_register_address = 4'h0;
      o_interrupt_ack_n = 1'b1;
   end
   // an undriven bus wanders so a stale value never passes as read data
   always @(posedge i_core_clk) float_q <= ~float_q;
   assign o_bus_line = !i_dev_data_oe_n ? i_dev_data : (host_oe ? host_d : float_q);
   task automatic cycle(input logic iack, input logic rd, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdata, output logic got);
      int n;
      rdata = 8'h00;
      got = 1'b0;
      n = 0;
      @(negedge i_core_clk);
      o_read_not_write = rd;
      o_register_address = a;
      host_d = wd;
      host_oe = !rd && !iack;
      if (iack) o_interrupt_ack_n = 1'b0;
      else o_chip_select_n = 1'b0;
      while (!got && n < 30) begin
         @(posedge i_core_clk);
         n++;
         if ((i_ack_oe_n ? 1'b1 : i_ack_n) === 1'b0) begin
            got = 1'b1;
            rdata = o_bus_line;
         end
      end
      @(negedge i_core_clk);
      o_chip_select_n = 1'b1;
      o_interrupt_ack_n = 1'b1;
      n = 0;
      while (i_ack_oe_n !== 1'b1 && n < 30) begin
         @(negedge i_core_clk);
         n++;
      end
      host_oe = 1'b0;
      repeat (4) @(negedge i_core_clk);
   endtask
endmodule

// File: test/dual_uart_host_bus_pins_bench.sv
// self-checking bench for the dual serial controller host port
`timescale 1ns/1ps
module dual_uart_host_bus_pins_bench;
   import dual_uart_pkg::*;
   localparam logic [CNT_W-1:0] SIM_BIT = 16'h0008;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic rx_a = 1'b1;
   logic cs_n, rw, iack_n, dout_oe_n, ack_n, ack_oe_n, irq_n, irq_oe_n, tx_a, tx_b;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] din, dout, port;
   logic irq_line;
   int n_fail = 0;
   int check_count = 0;
   assign irq_line = irq_oe_n ? 1'b1 : irq_n;
   always #12.5 i_core_clk = ~i_core_clk;
   dual_uart_host_model host_u (.i_core_clk(i_core_clk), .i_dev_data(dout), .i_dev_data_oe_n(dout_oe_n),
      .i_ack_oe_n(ack_oe_n), .i_ack_n(ack_n), .o_chip_select_n(cs_n), .o_read_not_write(rw),
      .o_register_address(addr), .o_interrupt_ack_n(iack_n), .o_bus_line(din));
   dual_uart_host_bus_pins #(.BIT_CYCLES(SIM_BIT), .FIFO_DEPTH(32)) dut_u (.i_core_clk(i_core_clk),
      .i_rst(i_rst), .i_clk_en(1'b1), .i_chip_select_n(cs_n), .i_read_not_write(rw),
      .i_register_address(addr), .i_host_data_bus(din), .o_host_data_bus(dout),
      .o_host_data_bus_oe_n(dout_oe_n), .o_transfer_ack_n(ack_n), .o_transfer_ack_oe_n(ack_oe_n),
      .o_interrupt_request_n(irq_n), .o_interrupt_request_oe_n(irq_oe_n), .i_interrupt_ack_n(iack_n),
      .i_serial_in_first_channel(rx_a), .i_serial_in_second_channel(1'b1),
      .o_serial_out_first_channel(tx_a), .o_serial_out_second_channel(tx_b), .o_output_port_pins(port));
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp1(input string what, input logic exp, input logic got);
      cmp8(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic g;
      host_u.cycle(1'b0, 1'b0, a, d, r, g);
      cmp1("write ack", 1'b1, g);
   endtask
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] r;
      logic g;
      host_u.cycle(1'b0, 1'b1, a, 8'h00, r, g);
      cmp1("read ack", 1'b1, g);
      cmp8(what, exp, r);
   endtask
   task automatic iack_chk(input logic exp_got, input logic [7:0] exp);
      logic [7:0] r;
      logic g;
      host_u.cycle(1'b1, 1'b1, 4'h0, 8'h00, r, g);
      cmp1("iack ack", exp_got, g);
      if (exp_got) cmp8("vector", exp, r);
   endtask
   task automatic t_reset;
      cmp1("tx a", 1'b1, tx_a);
      cmp1("tx b", 1'b1, tx_b);
      cmp8("port", 8'hFF, port);
      rd_chk("vector", 4'h5, 8'h0F);
      rd_chk("status a", 4'h1, 8'h00);
      rd_chk("isr", 4'h4, 8'h00);
      rd_chk("opcr", 4'h6, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_regs;
      wr(4'h7, 8'h3C);
      rd_chk("port reg", 4'h7, 8'h3C);
      cmp8("port set", 8'hC3, port);
      wr(4'hE, 8'h0C);
      cmp8("port clr", 8'hCF, port);
      rd_chk("unmapped", 4'hC, 8'h00);
      wr(4'h5, 8'hA5);
      rd_chk("vector wr", 4'h5, 8'hA5);
      $display("test registers done");
   endtask
   task automatic t_tx;
      logic [9:0] f;
      int n;
      f = {1'b1, 8'hA6, 1'b0};
      n = 0;
      wr(4'h2, 8'h04);
      // the start bit begins before the write cycle ends, so watch the line alongside it
      fork
         wr(4'h3, 8'hA6);
         begin
            while (tx_a === 1'b1 && n < 200) begin
               @(negedge i_core_clk);
               n++;
            end
            repeat (SIM_BIT / 2) @(negedge i_core_clk);
            for (int i = 0; i < 10; i++) begin
               cmp1("tx bit", f[i], tx_a);
               repeat (SIM_BIT) @(negedge i_core_clk);
            end
         end
      join
      cmp1("tx idle", 1'b1, tx_a);
      rd_chk("isr tx", 4'h4, 8'h01);
      $display("test transmit done");
   endtask
   task automatic t_rx_irq;
      logic [9:0] f;
      f = {1'b1, 8'h3D, 1'b0};
      wr(4'h2, 8'h01);
      wr(4'h4, 8'h02);
      cmp1("irq masked", 1'b1, irq_line);
      for (int i = 0; i < 10; i++) begin
         rx_a = f[i];
         repeat (SIM_BIT) @(negedge i_core_clk);
      end
      repeat (6) @(negedge i_core_clk);
      cmp1("irq set", 1'b0, irq_line);
      iack_chk(1'b1, 8'hA5);
      rd_chk("status rx", 4'h1, 8'h0D);
      rd_chk("rx data", 4'h3, 8'h3D);
      cmp1("irq clear", 1'b1, irq_line);
      iack_chk(1'b0, 8'h00);
      $display("test receive done");
   endtask
   task automatic t_loop;
      int lows;
      lows = 0;
      wr(4'h0, 8'h13);
      wr(4'h0, 8'h80);
      wr(4'h3, 8'h81);
      repeat (12 * SIM_BIT) begin
         @(negedge i_core_clk);
         if (tx_a !== 1'b1) lows++;
      end
      cmp1("loop mark", 1'b1, lows == 0);
      rd_chk("loop data", 4'h3, 8'h81);
      wr(4'h2, 8'h10);
      rd_chk("first mode", 4'h0, 8'h13);
      $display("test loopback done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge i_core_clk);
      i_rst = 1'b0;
      @(negedge i_core_clk);
      t_reset();
      t_regs();
      t_tx();
      t_rx_irq();
      t_loop();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge i_core_clk);
      n_fail++;
      $display("BAD watchdog expected end seen hang");
      stop_test();
   end
endmodule
